// ---- inc/rcr_pkg.sv ----
// Purpose: constants for the radio control register bank
// Assumes: 16-bit registers, 7-bit register address, spi mode 0
// Notes: reset values are plain defaults; only bits listed here are stored
package rcr_pkg;
    localparam int RCR_ADDR_W = 7;
    localparam int RCR_DATA_W = 16;
    // register offsets
    localparam logic [6:0] RCR_OFS_LOCK = 7'h03;
    localparam logic [6:0] RCR_OFS_RSSI = 7'h06;
    localparam logic [6:0] RCR_OFS_STATE = 7'h07;
    localparam logic [6:0] RCR_OFS_GAIN = 7'h09;
    localparam logic [6:0] RCR_OFS_OSC = 7'h0a;
    localparam logic [6:0] RCR_OFS_TEST = 7'h0b;
    // field positions
    localparam int RCR_LOCK_BIT = 12;
    localparam int RCR_RSSI_LSB = 10;
    localparam int RCR_TX_START_BIT = 8;
    localparam int RCR_RX_START_BIT = 7;
    localparam int RCR_CHAN_LSB = 0;
    localparam int RCR_AMP_LSB = 7;
    localparam int RCR_OSC_BIT = 0;
    localparam int RCR_CW_BIT = 15;
    localparam int RCR_RSSI_OFF_BIT = 9;
    // reset values
    localparam logic [6:0] RCR_CHAN_RST = 7'h00;
    localparam logic [3:0] RCR_AMP_RST = 4'h0;
    localparam logic RCR_OSC_RST = 1'b1;
    // spi command: first bit 1 = read
    localparam int RCR_FRAME_BITS = 24;
    typedef enum logic [2:0] {
        RCR_ST_IDLE = 3'b001,
        RCR_ST_TX = 3'b010,
        RCR_ST_RX = 3'b100
    } rcr_radio_t;
endpackage : rcr_pkg

// ---- rtl/rcr_spi_shift.sv ----
// Purpose: spi slave shifter for the register bank, mode 0, msb first
// Assumes: sclk, cs and mosi are synchronous inputs sampled on clk_i
// Notes: frame = rw bit, 7 address bits, 16 data bits
`timescale 1ns/1ps
module rcr_spi_shift
    import rcr_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    input wire logic [15:0] rd_data_i,
    output logic spi_miso_o,
    output logic [6:0] addr_o,
    output logic addr_vld_o,
    output logic [15:0] wr_data_o,
    output logic wr_stb_o
);
    logic sclk_reg;
    logic [4:0] cnt_reg;
    logic [23:0] sh_reg;
    logic rd_reg;
    logic [15:0] out_reg;
    logic rise;
    logic fall;

    assign rise = spi_sclk_i & ~sclk_reg & ~spi_cs_n_i;
    assign fall = ~spi_sclk_i & sclk_reg & ~spi_cs_n_i;

    ////////////////////////////////////////////////////////////////////////
    // edge history
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sclk_reg <= 1'b0;
        else
            sclk_reg <= spi_sclk_i;
    end

    // capture on rising sclk, decode at bit 8 and bit 24
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cnt_reg <= 5'h00;
            sh_reg <= 24'h000000;
            rd_reg <= 1'b0;
            addr_o <= 7'h00;
            addr_vld_o <= 1'b0;
            wr_data_o <= 16'h0000;
            wr_stb_o <= 1'b0;
        end
        else
        begin
            addr_vld_o <= 1'b0;
            wr_stb_o <= 1'b0;
            if (spi_cs_n_i)
                cnt_reg <= 5'h00;
            else if (rise)
            begin
                sh_reg <= {sh_reg[22:0], spi_mosi_i};
                cnt_reg <= cnt_reg + 5'h01;
                if (cnt_reg == 5'h07)
                begin
                    rd_reg <= sh_reg[6];
                    addr_o <= {sh_reg[5:0], spi_mosi_i};
                    addr_vld_o <= 1'b1;
                end
                if (cnt_reg == 5'(RCR_FRAME_BITS - 1) && !rd_reg)
                begin
                    wr_data_o <= {sh_reg[14:0], spi_mosi_i};
                    wr_stb_o <= 1'b1;
                end
            end
        end
    end

    // miso shift; read data loaded after address is known
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            out_reg <= 16'h0000;
            spi_miso_o <= 1'b0;
        end
        else if (spi_cs_n_i)
            spi_miso_o <= 1'b0;
        else if (fall && cnt_reg == 5'h08)
        begin
            spi_miso_o <= rd_data_i[15];
            out_reg <= {rd_data_i[14:0], 1'b0};
        end
        else if (fall && cnt_reg > 5'h08)
        begin
            spi_miso_o <= out_reg[15];
            out_reg <= {out_reg[14:0], 1'b0};
        end
    end
endmodule : rcr_spi_shift

// ---- rtl/rcr_regs.sv ----
// Purpose: radio control and status register bank behind spi
// Assumes: analog status arrives synchronous on clk_i
// Notes: start bits stay as written; host clears them for idle
//
// Behaviour
// - every register here is read over the spi slave port; only registers 7, 9, 10 and 11 are also written.
// - bit 12 of register 3 reads 1 while the synthesizer is locked.
// - bits 15:10 of register 6 carry the 6-bit raw signal strength.
// - writing 1 to bit 8 of register 7 starts the transmit sequence.
// - writing 1 to bit 7 of register 7 starts the receive sequence.
// - bits 6:0 of register 7 pick the channel for transmit and receive.
// - bits 10:7 of register 9 set the amplifier level.
// - bit 0 of register 10 turns the oscillator gain block on.
// - bit 15 of register 11 selects an unmodulated carrier.
// - bit 9 of register 11 turns signal strength measurement off.
// - in carrier mode the transmitter runs unmodulated while only the transmit start bit is set.
`timescale 1ns/1ps
module rcr_regs
    import rcr_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    input wire logic synthesizer_locked_i,
    input wire logic [5:0] raw_signal_strength_i,
    output logic tx_start_o,
    output logic rx_start_o,
    output logic tx_on_o,
    output logic rx_on_o,
    output logic modulation_on_o,
    output logic [6:0] channel_number_o,
    output logic [3:0] amplifier_level_o,
    output logic oscillator_gain_on_o,
    output logic signal_strength_off_o
);
    import rcr_pkg::*;

    logic [6:0] addr;
    logic addr_vld;
    logic [15:0] wr_data;
    logic wr_stb;
    logic [15:0] rd_mux;
    logic [15:0] rd_reg;
    logic tx_en_reg;
    logic rx_en_reg;
    logic cw_reg;
    logic [5:0] rssi_reg;
    rcr_radio_t radio_reg;
    rcr_radio_t radio_next;

    ////////////////////////////////////////////////////////////////////////
    // serial access
    rcr_spi_shift u_spi (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .spi_sclk_i(spi_sclk_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_mosi_i(spi_mosi_i),
        .rd_data_i(rd_reg),
        .spi_miso_o(spi_miso_o),
        .addr_o(addr),
        .addr_vld_o(addr_vld),
        .wr_data_o(wr_data),
        .wr_stb_o(wr_stb)
    );

    ////////////////////////////////////////////////////////////////////////
    // writable fields; unlisted offsets and bits are ignored
    // register 7: start bits and channel
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tx_en_reg <= 1'b0;
            rx_en_reg <= 1'b0;
            channel_number_o <= RCR_CHAN_RST;
        end
        else if (wr_stb && addr == RCR_OFS_STATE)
        begin
            tx_en_reg <= wr_data[RCR_TX_START_BIT];
            rx_en_reg <= wr_data[RCR_RX_START_BIT];
            channel_number_o <= wr_data[RCR_CHAN_LSB +: 7];
        end
    end

    // register 9: amplifier level
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            amplifier_level_o <= RCR_AMP_RST;
        else if (wr_stb && addr == RCR_OFS_GAIN)
            amplifier_level_o <= wr_data[RCR_AMP_LSB +: 4];
    end

    // register 10: oscillator gain block
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            oscillator_gain_on_o <= RCR_OSC_RST;
        else if (wr_stb && addr == RCR_OFS_OSC)
            oscillator_gain_on_o <= wr_data[RCR_OSC_BIT];
    end

    // register 11: carrier and measurement test bits
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cw_reg <= 1'b0;
            signal_strength_off_o <= 1'b0;
        end
        else if (wr_stb && addr == RCR_OFS_TEST)
        begin
            cw_reg <= wr_data[RCR_CW_BIT];
            signal_strength_off_o <= wr_data[RCR_RSSI_OFF_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // radio sequencing from the start bits; both set is held idle
    always_comb
    begin
        case ({tx_en_reg, rx_en_reg})
            2'b10: radio_next = RCR_ST_TX;
            2'b01: radio_next = RCR_ST_RX;
            default: radio_next = RCR_ST_IDLE;
        endcase
    end

    // radio state register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            radio_reg <= RCR_ST_IDLE;
        else
            radio_reg <= radio_next;
    end

    // one-cycle start pulses on entry to the tx or rx state
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tx_start_o <= 1'b0;
            rx_start_o <= 1'b0;
        end
        else
        begin
            tx_start_o <= radio_next == RCR_ST_TX && radio_reg != RCR_ST_TX;
            rx_start_o <= radio_next == RCR_ST_RX && radio_reg != RCR_ST_RX;
        end
    end

    // transmitter and receiver levels
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tx_on_o <= 1'b0;
            rx_on_o <= 1'b0;
        end
        else
        begin
            tx_on_o <= radio_next == RCR_ST_TX;
            rx_on_o <= radio_next == RCR_ST_RX;
        end
    end

    // modulation only while transmitting outside carrier mode
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            modulation_on_o <= 1'b0;
        else
            modulation_on_o <= radio_next == RCR_ST_TX && !cw_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // signal strength sample, frozen while measurement is off
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rssi_reg <= 6'h00;
        else if (!signal_strength_off_o)
            rssi_reg <= raw_signal_strength_i;
    end

    // read mux; reserved bits read zero
    always_comb
    begin
        rd_mux = 16'h0000;
        case (addr)
            RCR_OFS_LOCK: rd_mux[RCR_LOCK_BIT] = synthesizer_locked_i;
            RCR_OFS_RSSI: rd_mux[RCR_RSSI_LSB +: 6] = rssi_reg;
            RCR_OFS_STATE:
            begin
                rd_mux[RCR_TX_START_BIT] = tx_en_reg;
                rd_mux[RCR_RX_START_BIT] = rx_en_reg;
                rd_mux[RCR_CHAN_LSB +: 7] = channel_number_o;
            end
            RCR_OFS_GAIN: rd_mux[RCR_AMP_LSB +: 4] = amplifier_level_o;
            RCR_OFS_OSC: rd_mux[RCR_OSC_BIT] = oscillator_gain_on_o;
            RCR_OFS_TEST:
            begin
                rd_mux[RCR_CW_BIT] = cw_reg;
                rd_mux[RCR_RSSI_OFF_BIT] = signal_strength_off_o;
            end
            default: rd_mux = 16'h0000;
        endcase
    end

    // read data captured once the address is decoded
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rd_reg <= 16'h0000;
        else if (addr_vld)
            rd_reg <= rd_mux;
    end
endmodule : rcr_regs

// ---- test/rcr_regs_asserts.sv ----
// Purpose: port checks for the radio control register bank
// Assumes: sees rcr_regs ports only
// Notes: outputs settle within 4 clk of cs rising
`timescale 1ns/1ps
module rcr_regs_asserts
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_o,
    input wire logic tx_start_o,
    input wire logic rx_start_o,
    input wire logic tx_on_o,
    input wire logic rx_on_o,
    input wire logic modulation_on_o,
    input wire logic [6:0] channel_number_o,
    input wire logic [3:0] amplifier_level_o,
    input wire logic oscillator_gain_on_o,
    input wire logic signal_strength_off_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // radio state and pulses
    a_not_both_on: assert property (!(tx_on_o && rx_on_o)) else $error("tx and rx both on");
    a_tx_pulse_entry: assert property (tx_start_o == $rose(tx_on_o))
        else $error("tx start pulse not tied to tx entry");
    a_rx_pulse_entry: assert property (rx_start_o == $rose(rx_on_o))
        else $error("rx start pulse not tied to rx entry");
    a_tx_pulse_single: assert property (tx_start_o |=> !tx_start_o)
        else $error("tx start pulse too long");
    a_mod_needs_tx: assert property (modulation_on_o |-> tx_on_o)
        else $error("modulation without tx");
    // nothing moves between frames
    a_fields_hold: assert property (spi_cs_n_i [*4] |-> $stable({channel_number_o,
        amplifier_level_o, oscillator_gain_on_o, signal_strength_off_o}))
        else $error("field changed outside a frame");
    a_radio_hold: assert property (spi_cs_n_i [*4] |->
        $stable({tx_on_o, rx_on_o, modulation_on_o})) else $error("radio state moved idle");
    a_miso_quiet: assert property (spi_cs_n_i [*2] |-> !spi_miso_o)
        else $error("miso driven while deselected");
    c_tx: cover property (tx_start_o);
    c_rx: cover property (rx_start_o);
    c_cw: cover property ($fell(modulation_on_o) && tx_on_o);
endmodule : rcr_regs_asserts

// ---- test/rcr_spi_host.sv ----
// Purpose: spi master model for the host controller
// Assumes: mode 0, msb first, 24-bit frames
// Notes: half is the sclk half period in clk cycles, at least 2
`timescale 1ns/1ps
module rcr_spi_host
(
    input wire logic clk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    int half = 2;
    // idle: deselected, clock low
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b1;
    end
    // one whole frame, any 7-bit address
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [15:0] d,
        output logic [15:0] q);
        logic [23:0] f;
        f = {rw, a, d};
        q = 16'h0000;
        @(posedge clk_i) #2;
        cs_n_o = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            mosi_o = f[i];
            repeat (half) @(posedge clk_i);
            #2 sclk_o = 1'b1;
            if (i < 16) q[i] = miso_i;
            repeat (half) @(posedge clk_i);
            #2 sclk_o = 1'b0;
        end
        repeat (half) @(posedge clk_i);
        #2 cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // no stale data after release
        repeat (4) @(posedge clk_i);
    endtask : xfer
endmodule : rcr_spi_host

// ---- test/radio_control_registers_test.sv ----
// Purpose: self-checking bench for the radio control register bank
// Assumes: host model drives spi, 20 MHz clock
// Notes: status inputs change 2 ns after rising edges
`timescale 1ns/1ps
module radio_control_registers_test;
    import rcr_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic lock = 1'b0;
    logic [5:0] strength = 6'h00;
    logic sclk, cs_n, mosi, miso, tx_start, rx_start, tx_on, rx_on, mod_on, osc_on, ss_off;
    logic [6:0] chan;
    logic [3:0] amp;
    logic [15:0] q;
    logic [15:0] outs;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_tx_pulse = 0;
    int n_rx_pulse = 0;
    assign outs = {chan, amp, osc_on, ss_off, tx_on, rx_on, mod_on};
    rcr_spi_host host (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
    rcr_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .synthesizer_locked_i(lock),
        .raw_signal_strength_i(strength), .tx_start_o(tx_start), .rx_start_o(rx_start),
        .tx_on_o(tx_on), .rx_on_o(rx_on), .modulation_on_o(mod_on), .channel_number_o(chan),
        .amplifier_level_o(amp), .oscillator_gain_on_o(osc_on), .signal_strength_off_o(ss_off));
    // 50 ns clock
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    // hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    // start pulse counters
    always @(posedge clk_i)
    begin
        if (tx_start === 1'b1)
            n_tx_pulse++;
        if (rx_start === 1'b1)
            n_rx_pulse++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_status();
        #2 lock = 1'b1;
        strength = 6'h2a;
        host.xfer(1'b1, RCR_OFS_LOCK, 16'h0000, q);
        chk(q, 16'h1000);
        host.xfer(1'b1, RCR_OFS_RSSI, 16'h0000, q);
        chk(q, 16'ha800);
        #2 lock = 1'b0;
        host.xfer(1'b1, RCR_OFS_LOCK, 16'h0000, q);
        chk(q, 16'h0000);
    endtask : t_status
    task automatic t_tx_channel();
        host.xfer(1'b0, RCR_OFS_STATE, 16'h0105, q);
        chk(outs, {7'h05, 4'h0, 5'b10101});
        chk(16'(n_tx_pulse), 16'h0001);
        host.half = 5;
        host.xfer(1'b0, RCR_OFS_STATE, 16'h014e, q);
        host.half = 2;
        chk(outs, {7'h4e, 4'h0, 5'b10101});
        chk(16'(n_tx_pulse), 16'h0001);
        host.xfer(1'b1, RCR_OFS_STATE, 16'h0000, q);
        chk(q, 16'h014e);
    endtask : t_tx_channel
    task automatic t_carrier();
        host.xfer(1'b0, RCR_OFS_TEST, 16'h8200, q);
        chk(outs, {7'h4e, 4'h0, 5'b11100});
        host.xfer(1'b1, RCR_OFS_TEST, 16'h0000, q);
        chk(q, 16'h8200);
        #2 strength = 6'h15;
        host.xfer(1'b1, RCR_OFS_RSSI, 16'h0000, q);
        chk(q, 16'ha800);
    endtask : t_carrier
    task automatic t_gain();
        host.xfer(1'b0, RCR_OFS_GAIN, 16'h0780, q);
        host.xfer(1'b0, RCR_OFS_OSC, 16'h0000, q);
        chk(outs, {7'h4e, 4'hf, 5'b01100});
        host.xfer(1'b1, RCR_OFS_GAIN, 16'h0000, q);
        chk(q, 16'h0780);
    endtask : t_gain
    task automatic t_modes();
        host.xfer(1'b0, RCR_OFS_STATE, 16'h00ce, q);
        chk(outs, {7'h4e, 4'hf, 5'b01010});
        chk(16'(n_rx_pulse), 16'h0001);
        host.xfer(1'b0, RCR_OFS_STATE, 16'h004e, q);
        chk(outs, {7'h4e, 4'hf, 5'b01000});
        host.xfer(1'b0, RCR_OFS_STATE, 16'h014e, q);
        chk(outs, {7'h4e, 4'hf, 5'b01100});
        chk(16'(n_tx_pulse), 16'h0002);
        host.xfer(1'b1, 7'h05, 16'h0000, q);
        chk(q, 16'h0000);
    endtask : t_modes
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_i);
        #2 resetn_i = 1'b1;
        repeat (2) @(posedge clk_i);
        chk(outs, {RCR_CHAN_RST, RCR_AMP_RST, RCR_OSC_RST, 4'h0});
        chk(16'(n_tx_pulse + n_rx_pulse), 16'h0000);
        t_status();
        t_tx_channel();
        t_carrier();
        t_gain();
        t_modes();
        print_verdict();
    end
endmodule : radio_control_registers_test
bind rcr_regs rcr_regs_asserts chk_i (.clk_i, .resetn_i, .spi_cs_n_i, .spi_miso_o,
    .tx_start_o, .rx_start_o, .tx_on_o, .rx_on_o, .modulation_on_o, .channel_number_o,
    .amplifier_level_o, .oscillator_gain_on_o, .signal_strength_off_o);
